// ---- common/i2crx_params.svh ----
/*
 * offsets, field positions, reset values and timing counts of the
 * two-wire master receive block.
 * assumes: included by bare name; word-aligned ahb-lite register map.
 */
`ifndef I2CRX_PARAMS_SVH
`define I2CRX_PARAMS_SVH

// register byte offsets (low address byte)
`define I2CRX_OFF_CTRL      8'h00
`define I2CRX_OFF_BUF       8'h04
`define I2CRX_OFF_STAT      8'h08
`define I2CRX_OFF_IEN       8'h0C
`define I2CRX_OFF_ICLR      8'h10
`define I2CRX_OFF_BAUD      8'h14

// serial_control_register_two bit positions
`define I2CRX_CTRL_SEN      0
`define I2CRX_CTRL_PEN      2
`define I2CRX_CTRL_RECEIVE_ENABLE_BIT     3
`define I2CRX_CTRL_ACK_SEQUENCE_ENABLE_BIT    4
`define I2CRX_CTRL_ACK_DATA_BIT    5
`define I2CRX_CTRL_ACK_STATUS_BIT  6

// interrupt status / enable / clear layout
`define I2CRX_IRQ_EVT       0
`define I2CRX_IRQ_OVF       1
`define I2CRX_IRQ_WRITE_COLLISION_FLAG      2

// status register extra bits
`define I2CRX_STAT_BF       4
`define I2CRX_STAT_BUSY     5

// reset values
`define I2CRX_IEN_RST       3'h0
`define I2CRX_ACK_DATA_BIT_RST     1'b0

// timing: half of one scl period, and the system clock period
`define I2CRX_CLK_PERIOD_NS 5
`define I2CRX_HALF_BIT_NS   5000
`define I2CRX_HALF_BIT_CYC  (`I2CRX_HALF_BIT_NS / `I2CRX_CLK_PERIOD_NS)

`endif

// ---- common/i2crx_pkg.sv ----
/*
 * types of the two-wire master receive block.
 * assumes: constants come from i2crx_params.svh.
 */
package i2crx_pkg;

   // bus sequencer states
   typedef enum logic [2:0] {
      ST_IDLE,
      ST_START,
      ST_TX,
      ST_RX,
      ST_ACK,
      ST_STOP
   } i2crx_state_e;

   // whole state of the block, registered as one word
   typedef struct packed {
      i2crx_state_e state;        // sequencer state
      logic         phase;        // second step of start / stop
      logic         scl_rel;      // 1: scl released, 0: pulled low
      logic         sda_rel;      // 1: sda released, 0: pulled low
      logic [3:0]   bit_cnt;      // bits done in this byte
      logic [15:0]  baud_cnt;     // baud rate counter
      logic [15:0]  baud_reload;  // half period minus one
      logic [7:0]   shift;        // receive_shift_register
      logic [7:0]   rx_buf;       // serial_buffer_register
      logic         buffer_full;  // buffer_full_flag
      logic         ack_status;   // ack_status_bit
      logic         ack_data;     // ack_data_bit
      logic         receive_enable_bit;         // receive_enable_bit
      logic         start_enable_bit;          // start_enable_bit
      logic         pen;          // stop enable
      logic         ack_sequence_enable_bit;        // ack_sequence_enable_bit
      logic [2:0]   int_sts;      // sticky event bits
      logic [2:0]   int_en;       // event enables
      logic         sda_s1;       // sda synchroniser stages
      logic         sda_s2;
      logic         scl_s1;       // scl synchroniser stages
      logic         scl_s2;
      logic         wr_pend;      // write data phase pending
      logic [7:0]   wr_addr;      // its address byte
      logic [31:0]  hrdata;       // read data for the data phase
   } i2crx_regs_s;

endpackage

// ---- hw/i2crx_top.sv ----
/*
 * master-mode receive path of a two-wire serial port, with start, stop,
 * address send, byte receive and master acknowledge, behind an ahb-lite
 * register slave.
 * assumes: one 200 MHz clock; scl/sda are open-drain, resolved outside;
 * a single ahb-lite master doing word transfers.
 */
`timescale 1ns/10ps
`include "i2crx_params.svh"

module i2crx_top #(
   parameter int BAUD_DEFAULT = `I2CRX_HALF_BIT_CYC  // half scl period in cycles
) (
   input  wire logic        ref_clk_i,
   input  wire logic        rst_i,
   input  wire logic        hsel_i,
   input  wire logic [31:0] haddr_i,
   input  wire logic [1:0]  htrans_i,
   input  wire logic        hwrite_i,
   input  wire logic [2:0]  hsize_i,
   input  wire logic [31:0] hwdata_i,
   input  wire logic        hready_i,
   output logic             hreadyout_o,
   output logic             hresp_o,
   output logic [31:0]      hrdata_o,
   input  wire logic        scl_i,
   output logic             scl_o,
   output logic             scl_oe_o,
   input  wire logic        sda_i,
   output logic             sda_o,
   output logic             sda_oe_o,
   output logic             irq_o
);

   // the counter is 16 bits wide and a half period needs at least two cycles;
   // refused at elaboration so a bad build never reaches silicon
   if (BAUD_DEFAULT < 2 || BAUD_DEFAULT > 65536) begin : g_baud_range
      $error("BAUD_DEFAULT out of range");
   end

   localparam logic [15:0] BaudRst = 16'(BAUD_DEFAULT - 1);

   i2crx_pkg::i2crx_regs_s q_reg;   // present state
   i2crx_pkg::i2crx_regs_s q_next;  // next state

   logic       acc;        // address phase accepted
   logic       stretch;    // slave holds scl low while we release it
   logic       tick;       // baud counter rollover
   logic       fall;       // tick while scl is released (scl falls in byte and ack steps)
   logic       idle;       // sequencer idle
   logic       wr_ctrl;    // control write in data phase
   logic       wr_buf;     // buffer write in data phase
   logic       rd_buf;     // buffer read accepted
   logic       rx_done;    // eighth receive bit completes
   logic       tx_done;    // ninth address clock completes
   logic [2:0] set_sts;    // event bits raised this cycle

   // qualifying terms shared by the update logic and the checks
   always_comb begin
      acc     = hsel_i & htrans_i[1] & hready_i & (hsize_i == 3'h2);
      idle    = (q_reg.state == i2crx_pkg::ST_IDLE);
      stretch = q_reg.scl_rel & ~q_reg.scl_s2;
      tick    = ~idle & (q_reg.baud_cnt == 16'h0000) & ~stretch;
      fall    = tick & q_reg.scl_rel;
      wr_ctrl = q_reg.wr_pend & (q_reg.wr_addr == `I2CRX_OFF_CTRL);
      wr_buf  = q_reg.wr_pend & (q_reg.wr_addr == `I2CRX_OFF_BUF);
      rd_buf  = acc & ~hwrite_i & (haddr_i[7:0] == `I2CRX_OFF_BUF);
      rx_done = fall & (q_reg.state == i2crx_pkg::ST_RX) & (q_reg.bit_cnt == 4'h7);
      tx_done = fall & (q_reg.state == i2crx_pkg::ST_TX) & (q_reg.bit_cnt == 4'h8);
   end

   // next state: bus slave, command decode, sequencer and event flags
   always_comb begin
      q_next  = q_reg;
      set_sts = 3'h0;

      // two-flop synchronisers for the open-drain lines
      q_next.sda_s1 = sda_i;
      q_next.sda_s2 = q_reg.sda_s1;
      q_next.scl_s1 = scl_i;
      q_next.scl_s2 = q_reg.scl_s1;

      // baud counter only runs while a sequence is active
      if (idle) begin
         q_next.baud_cnt = q_reg.baud_reload;
      end else if (!stretch) begin
         q_next.baud_cnt = tick ? q_reg.baud_reload : q_reg.baud_cnt - 16'h0001;
      end

      // sequencer steps on each rollover
      if (tick) begin
         case (q_reg.state)
            i2crx_pkg::ST_START: begin
               if (!q_reg.phase) begin
                  q_next.sda_rel = 1'b0;   // sda falls while scl high
                  q_next.phase   = 1'b1;
               end else begin
                  q_next.scl_rel = 1'b0;
                  q_next.start_enable_bit     = 1'b0;
                  q_next.state   = i2crx_pkg::ST_IDLE;
                  set_sts[`I2CRX_IRQ_EVT] = 1'b1;
               end
            end
            i2crx_pkg::ST_STOP: begin
               if (!q_reg.phase) begin
                  q_next.scl_rel = 1'b1;
                  q_next.phase   = 1'b1;
               end else begin
                  q_next.sda_rel = 1'b1;   // sda rises while scl high
                  q_next.pen     = 1'b0;
                  q_next.state   = i2crx_pkg::ST_IDLE;
                  set_sts[`I2CRX_IRQ_EVT] = 1'b1;
               end
            end
            i2crx_pkg::ST_TX, i2crx_pkg::ST_RX, i2crx_pkg::ST_ACK: begin
               q_next.scl_rel = ~q_reg.scl_rel;
               if (q_reg.scl_rel) begin
                  // end of a high phase: sample sda on receive bits and the address ack, then scl goes low
                  q_next.bit_cnt = q_reg.bit_cnt + 4'h1;
                  if (q_reg.state == i2crx_pkg::ST_TX) begin
                     if (q_reg.bit_cnt == 4'h8) begin
                        q_next.ack_status = q_reg.sda_s2;
                        q_next.state      = i2crx_pkg::ST_IDLE;
                        set_sts[`I2CRX_IRQ_EVT] = 1'b1;
                     end else begin
                        q_next.shift   = {q_reg.shift[6:0], 1'b0};
                        // release sda for the slave's acknowledge
                        q_next.sda_rel = (q_reg.bit_cnt == 4'h7) ? 1'b1 : q_reg.shift[6];
                     end
                  end else if (q_reg.state == i2crx_pkg::ST_RX) begin
                     q_next.shift = {q_reg.shift[6:0], q_reg.sda_s2};
                     if (q_reg.bit_cnt == 4'h7) begin
                        q_next.receive_enable_bit   = 1'b0;
                        q_next.rx_buf = {q_reg.shift[6:0], q_reg.sda_s2};
                        q_next.state  = i2crx_pkg::ST_IDLE;
                        set_sts[`I2CRX_IRQ_EVT] = 1'b1;
                        // a byte nobody has read yet is overrun
                        set_sts[`I2CRX_IRQ_OVF] = q_reg.buffer_full;
                     end
                  end else begin
                     q_next.sda_rel = 1'b1;
                     q_next.ack_sequence_enable_bit   = 1'b0;
                     q_next.state   = i2crx_pkg::ST_IDLE;
                     set_sts[`I2CRX_IRQ_EVT] = 1'b1;
                  end
               end
            end
            default: begin
               q_next.state = i2crx_pkg::ST_IDLE;
            end
         endcase
      end

      // write data phase of the register slave
      if (q_reg.wr_pend) begin
         q_next.wr_pend = 1'b0;
         case (q_reg.wr_addr)
            `I2CRX_OFF_CTRL: begin
               q_next.ack_data = hwdata_i[`I2CRX_CTRL_ACK_DATA_BIT];
               // commands start only from idle; otherwise disregarded
               if (idle) begin
                  q_next.phase = 1'b0;
                  if (hwdata_i[`I2CRX_CTRL_SEN]) begin
                     q_next.start_enable_bit     = 1'b1;
                     q_next.scl_rel = 1'b1;
                     q_next.sda_rel = 1'b1;
                     q_next.state   = i2crx_pkg::ST_START;
                  end else if (hwdata_i[`I2CRX_CTRL_PEN]) begin
                     q_next.pen     = 1'b1;
                     q_next.sda_rel = 1'b0;
                     q_next.state   = i2crx_pkg::ST_STOP;
                  end else if (hwdata_i[`I2CRX_CTRL_RECEIVE_ENABLE_BIT]) begin
                     q_next.receive_enable_bit    = 1'b1;
                     q_next.sda_rel = 1'b1;
                     q_next.bit_cnt = 4'h0;
                     q_next.state   = i2crx_pkg::ST_RX;
                  end else if (hwdata_i[`I2CRX_CTRL_ACK_SEQUENCE_ENABLE_BIT]) begin
                     q_next.ack_sequence_enable_bit   = 1'b1;
                     q_next.sda_rel = hwdata_i[`I2CRX_CTRL_ACK_DATA_BIT];
                     q_next.state   = i2crx_pkg::ST_ACK;
                  end
               end
            end
            `I2CRX_OFF_BUF: begin
               if (idle) begin
                  q_next.shift   = hwdata_i[7:0];
                  q_next.sda_rel = hwdata_i[7];
                  q_next.bit_cnt = 4'h0;
                  q_next.state   = i2crx_pkg::ST_TX;
               end else begin
                  set_sts[`I2CRX_IRQ_WRITE_COLLISION_FLAG] = 1'b1;
               end
            end
            `I2CRX_OFF_IEN:  q_next.int_en = hwdata_i[2:0];
            `I2CRX_OFF_ICLR: q_next.int_sts = q_reg.int_sts & ~hwdata_i[2:0];
            `I2CRX_OFF_BAUD: begin
               // a reload below one would stall the counter at zero
               if (hwdata_i[15:0] != 16'h0000) begin
                  q_next.baud_reload = hwdata_i[15:0];
               end
            end
            default: begin
               q_next.wr_pend = 1'b0;  // unmapped: ignored
            end
         endcase
      end

      // read clear first so that a byte landing now keeps its flag
      if (rd_buf) begin
         q_next.buffer_full = 1'b0;
      end
      if (rx_done) begin
         q_next.buffer_full = 1'b1;
      end
      q_next.int_sts = q_next.int_sts | set_sts;

      // address phase of the register slave
      if (acc) begin
         q_next.wr_pend = hwrite_i;
         q_next.wr_addr = haddr_i[7:0];
         q_next.hrdata  = 32'h0000_0000;
         if (!hwrite_i) begin
            case (haddr_i[7:0])
               `I2CRX_OFF_CTRL: begin
                  q_next.hrdata[`I2CRX_CTRL_SEN]     = q_reg.start_enable_bit;
                  q_next.hrdata[`I2CRX_CTRL_PEN]     = q_reg.pen;
                  q_next.hrdata[`I2CRX_CTRL_RECEIVE_ENABLE_BIT]    = q_reg.receive_enable_bit;
                  q_next.hrdata[`I2CRX_CTRL_ACK_SEQUENCE_ENABLE_BIT]   = q_reg.ack_sequence_enable_bit;
                  q_next.hrdata[`I2CRX_CTRL_ACK_DATA_BIT]   = q_reg.ack_data;
                  q_next.hrdata[`I2CRX_CTRL_ACK_STATUS_BIT] = q_reg.ack_status;
               end
               `I2CRX_OFF_BUF:  q_next.hrdata[7:0] = q_reg.rx_buf;
               `I2CRX_OFF_STAT: begin
                  q_next.hrdata[2:0]              = q_reg.int_sts;
                  q_next.hrdata[`I2CRX_STAT_BF]   = q_reg.buffer_full;
                  q_next.hrdata[`I2CRX_STAT_BUSY] = ~idle;
               end
               `I2CRX_OFF_IEN:  q_next.hrdata[2:0]  = q_reg.int_en;
               `I2CRX_OFF_BAUD: q_next.hrdata[15:0] = q_reg.baud_reload;
               default: begin
                  q_next.hrdata = 32'h0000_0000;  // unmapped and write-only read zero
               end
            endcase
         end
      end
   end

   // state register; lines released and flags clear after reset
   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         q_reg             <= '0;
         q_reg.state       <= i2crx_pkg::ST_IDLE;
         q_reg.scl_rel     <= 1'b1;
         q_reg.sda_rel     <= 1'b1;
         q_reg.sda_s1      <= 1'b1;
         q_reg.sda_s2      <= 1'b1;
         q_reg.scl_s1      <= 1'b1;
         q_reg.scl_s2      <= 1'b1;
         q_reg.baud_cnt    <= BaudRst;
         q_reg.baud_reload <= BaudRst;
         q_reg.ack_data    <= `I2CRX_ACK_DATA_BIT_RST;
         q_reg.int_en      <= `I2CRX_IEN_RST;
      end else begin
         q_reg <= q_next;
      end
   end

   // zero-wait slave: always ready, always okay
   assign hreadyout_o = 1'b1;
   assign hresp_o     = 1'b0;
   assign hrdata_o    = q_reg.hrdata;
   // open drain: only ever drive low
   assign scl_o       = 1'b0;
   assign sda_o       = 1'b0;
   assign scl_oe_o    = ~q_reg.scl_rel;
   assign sda_oe_o    = ~q_reg.sda_rel;
   assign irq_o       = |(q_reg.int_sts & q_reg.int_en);

   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (rst_i);

   sequence s_start_first;
      q_reg.state == i2crx_pkg::ST_START && tick && !q_reg.phase;
   endsequence

   sequence s_start_last;
      q_reg.state == i2crx_pkg::ST_START && tick && q_reg.phase;
   endsequence

   a_rx_begin: assert property (wr_ctrl && idle && hwdata_i[`I2CRX_CTRL_RECEIVE_ENABLE_BIT] && !hwdata_i[`I2CRX_CTRL_SEN] && !hwdata_i[`I2CRX_CTRL_PEN] |=> q_reg.state == i2crx_pkg::ST_RX && q_reg.receive_enable_bit) else $error("receive did not start");
   a_busy_ignore: assert property (wr_ctrl && (q_reg.state == i2crx_pkg::ST_TX || q_reg.state == i2crx_pkg::ST_START) |=> q_reg.state != i2crx_pkg::ST_RX) else $error("busy receive request taken");
   a_scl_toggle: assert property (q_reg.state == i2crx_pkg::ST_RX && tick |=> q_reg.scl_rel != $past(q_reg.scl_rel)) else $error("scl did not toggle");
   a_rx_complete: assert property (rx_done |=> q_reg.buffer_full && q_reg.int_sts[`I2CRX_IRQ_EVT] && !q_reg.receive_enable_bit && q_reg.rx_buf == {$past(q_reg.shift[6:0]), $past(q_reg.sda_s2)}) else $error("byte completion wrong");
   a_scl_held: assert property (rx_done |=> !q_reg.scl_rel && idle ##1 (!q_reg.scl_rel || !idle)) else $error("scl not held low");
   a_read_clear: assert property (rd_buf && !rx_done |=> !q_reg.buffer_full) else $error("buffer full not cleared");
   a_ovf_set: assert property (rx_done && q_reg.buffer_full && !rd_buf |=> q_reg.int_sts[`I2CRX_IRQ_OVF]) else $error("overflow missed");
   a_write_collision_flag_set: assert property (wr_buf && !idle && !rx_done |=> q_reg.int_sts[`I2CRX_IRQ_WRITE_COLLISION_FLAG] && $stable(q_reg.rx_buf)) else $error("collision wrong");
   a_start_sda: assert property (s_start_first |=> !q_reg.sda_rel && q_reg.phase) else $error("start sda not low");
   a_start_done: assert property (s_start_last |=> idle && q_reg.int_sts[`I2CRX_IRQ_EVT] && !q_reg.scl_rel) else $error("start end wrong");
   a_addr_begin: assert property (wr_buf && idle |=> q_reg.state == i2crx_pkg::ST_TX && q_reg.sda_rel == $past(hwdata_i[7])) else $error("address send did not start");
   a_ack_sample: assert property (tx_done |=> q_reg.ack_status == $past(q_reg.sda_s2) && q_reg.int_sts[`I2CRX_IRQ_EVT] && idle) else $error("ack sample wrong");
   a_ack_drive: assert property (q_reg.state == i2crx_pkg::ST_ACK && !fall |=> q_reg.sda_rel == $past(q_reg.sda_rel)) else $error("ack level moved");

endmodule

// ---- sim/i2crx_slave_model.sv ----
/* slave device model for the two-wire bus: acks its address, returns bytes
 * msb first, records the master's ack level and any stop.
 * assumes: scl and sda are resolved wires with pull-ups. */
`timescale 1ns/10ps

module i2crx_slave_model (
   input  wire logic       scl_i,      // resolved clock wire
   input  wire logic       sda_i,      // resolved data wire
   input  wire logic [7:0] tx_byte_i,  // byte returned on the next read
   input  wire logic       ack_en_i,   // 1: acknowledge the address
   output logic            sda_pull_o, // 1: pull sda low
   output logic [7:0]      addr_o,     // address byte seen
   output logic            mack_o,     // last master ack level
   output logic            stop_o      // stop seen since last start
);
   int   cnt     = 100;  // scl falls since start; 100 means idle
   logic in_addr = 1'b0; // address byte phase

   // pull only while idle-free; a released line floats high on its pull-up
   assign sda_pull_o = in_addr ? (cnt == 8 && ack_en_i)
                     : (cnt >= 0 && cnt < 8 && !tx_byte_i[3'(7 - cnt)]);

   initial begin
      addr_o = 8'h00;
      mack_o = 1'b1;
      stop_o = 1'b0;
   end

   // start: sda falls while scl is high; the master moves sda in the same
   // step as scl falls, so let both wires settle before judging
   always @(negedge sda_i) begin
      #1;
      if (scl_i === 1'b1 && sda_i === 1'b0) begin
         cnt = -1;
         in_addr = 1'b1;
         stop_o = 1'b0;
      end
   end

   // stop: sda rises while scl is high, the slave lets go; settle first
   always @(posedge sda_i) begin
      #1;
      if (scl_i === 1'b1 && sda_i === 1'b1) begin
         cnt = 100;
         stop_o = 1'b1;
      end
   end

   // rising scl: take address bits, then the master's ack
   always @(posedge scl_i) begin
      if (in_addr && cnt >= 0 && cnt < 8)
         addr_o = {addr_o[6:0], sda_i};
      else if (!in_addr && cnt == 8)
         mack_o = sda_i;
   end

   // falling scl: next bit; a not-ack or an unacked address ends our turn
   always @(negedge scl_i) begin
      if (cnt < 100)
         cnt = cnt + 1;
      if (cnt == 9) begin
         cnt = ((in_addr && ack_en_i) || (!in_addr && !mack_o)) ? 0 : 100;
         in_addr = 1'b0;
      end
   end
endmodule

// ---- sim/tb.sv ----
/* self-checking bench: ahb-lite master tasks run start, address, byte
 * receive, ack and stop against the slave model.
 * assumes: the design carries its own assertions; scl half period shortened. */
`timescale 1ns/10ps
`include "i2crx_params.svh"
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin failures++; \
   $display("[FAIL] %s exp %h got %h", n, e, g); end end

module tb;
   localparam logic [31:0] ONE   = 32'h0000_0001;             // single bit
   localparam logic [31:0] START_ENABLE_BIT   = ONE << `I2CRX_CTRL_SEN;    // start_enable_bit
   localparam logic [31:0] PEN   = ONE << `I2CRX_CTRL_PEN;    // stop enable
   localparam logic [31:0] RECEIVE_ENABLE_BIT  = ONE << `I2CRX_CTRL_RECEIVE_ENABLE_BIT;   // receive_enable_bit
   localparam logic [31:0] ACK_SEQUENCE_ENABLE_BIT = ONE << `I2CRX_CTRL_ACK_SEQUENCE_ENABLE_BIT;  // ack_sequence_enable_bit
   localparam logic [31:0] ACKST = ONE << `I2CRX_CTRL_ACK_STATUS_BIT; // ack_status_bit
   logic        clk, rst, hsel, hwrite;  // clock, reset, bus controls
   logic [1:0]  htrans;                  // transfer type
   logic [2:0]  hsize;                   // always a word
   logic [31:0] haddr, hwdata, hrdata;   // bus address and data
   logic [31:0] rd;                      // last read word
   logic        hrdy, hresp, irq;        // slave answers
   logic        scl_oe, sda_oe, sda_pull; // open-drain enables
   logic        ack_en, mack, stop_seen, ack_data_bit; // slave side controls
   logic [7:0]  tx_byte, saddr, addr;    // slave data
   wire logic   scl_w = ~scl_oe;         // pull-ups: released reads high
   wire logic   sda_w = ~(sda_oe | sda_pull);
   int          failures = 0;
   int          compares = 0;
   int          seed = 32'hede1;

   i2crx_top #(.BAUD_DEFAULT(4)) DUT (
      .ref_clk_i(clk), .rst_i(rst), .hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans),
      .hwrite_i(hwrite), .hsize_i(hsize), .hwdata_i(hwdata), .hready_i(hrdy), .hreadyout_o(hrdy),
      .hresp_o(hresp), .hrdata_o(hrdata), .scl_i(scl_w), .scl_o(), .scl_oe_o(scl_oe),
      .sda_i(sda_w), .sda_o(), .sda_oe_o(sda_oe), .irq_o(irq));
   i2crx_slave_model u_slave (
      .scl_i(scl_w), .sda_i(sda_w), .tx_byte_i(tx_byte), .ack_en_i(ack_en),
      .sda_pull_o(sda_pull), .addr_o(saddr), .mack_o(mack), .stop_o(stop_seen));

   // 200 MHz system clock
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end

   task automatic wrap_up;
      if (failures == 0 && compares > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   // one single word transfer; hready is waited for, never assumed
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      hsel <= 1'b1;
      haddr <= {24'h00_0000, a};
      hwrite <= w;
      htrans <= 2'b10;
      for (int p = 0; p < 2; p++) begin
         n = 0;
         do begin
            @(posedge clk);
            n++;
         end while (hrdy !== 1'b1 && n < 50);
         if (n >= 50) begin
            failures++;
            wrap_up();
         end
         if (p == 0) begin
            htrans <= 2'b00;
            hsel <= 1'b0;
            hwdata <= d;
         end
      end
      rd = hrdata;
   endtask

   task automatic rd_chk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e, input string n);
      xfer(1'b0, a, 32'h0000_0000);
      `CHK(n, e, rd & m)
   endtask

   // irq is combinational from registers: look two edges on
   task automatic chk_irq(input logic e);
      repeat (2) @(posedge clk);
      `CHK("irq level", e, irq)
   endtask

   // poll the sticky event bit; a bound stands in for a hang
   task automatic wait_evt;
      int n;
      n = 0;
      do begin
         xfer(1'b0, `I2CRX_OFF_STAT, 32'h0000_0000);
         n++;
      end while (rd[`I2CRX_IRQ_EVT] !== 1'b1 && n < 400);
      if (n >= 400) begin
         failures++;
         wrap_up();
      end
   endtask

   task automatic clr_evt;
      xfer(1'b1, `I2CRX_OFF_ICLR, ONE);
   endtask

   // expected status after byte i: collision from byte 1, overflow from byte 3
   function automatic logic [31:0] exp_stat(input int i);
      exp_stat = ONE | (ONE << `I2CRX_STAT_BF);
      if (i >= 1)
         exp_stat = exp_stat | (ONE << `I2CRX_IRQ_WRITE_COLLISION_FLAG);
      if (i >= 3)
         exp_stat = exp_stat | (ONE << `I2CRX_IRQ_OVF);
   endfunction

   initial begin
      rst = 1'b1;
      hsel = 1'b0;
      haddr = 32'h0000_0000;
      htrans = 2'b00;
      hwrite = 1'b0;
      hsize = 3'h2;
      hwdata = 32'h0000_0000;
      tx_byte = 8'h00;
      ack_en = 1'b1;
      repeat (4) @(posedge clk);
      rst <= 1'b0;
      // reset values, access kinds, unmapped place
      rd_chk(`I2CRX_OFF_IEN, 32'hffff_ffff, 32'h0000_0000, "ien reset");
      rd_chk(8'h20, 32'hffff_ffff, 32'h0000_0000, "unmapped");
      rd_chk(`I2CRX_OFF_BAUD, 32'hffff_ffff, 32'h0000_0003, "baud reset");
      xfer(1'b1, `I2CRX_OFF_BAUD, 32'h0000_0000);
      xfer(1'b1, `I2CRX_OFF_BAUD, 32'h0000_0005);
      rd_chk(`I2CRX_OFF_BAUD, 32'hffff_ffff, 32'h0000_0005, "baud write");
      // start with the interrupt masked, then enabled, then cleared
      xfer(1'b1, `I2CRX_OFF_CTRL, START_ENABLE_BIT);
      wait_evt();
      chk_irq(1'b0);
      xfer(1'b1, `I2CRX_OFF_IEN, 32'h0000_0007);
      chk_irq(1'b1);
      clr_evt();
      chk_irq(1'b0);
      addr = {7'($random(seed)), 1'b1};
      xfer(1'b1, `I2CRX_OFF_BUF, {24'h00_0000, addr});
      // a receive request while the address still goes out must be dropped
      xfer(1'b1, `I2CRX_OFF_CTRL, RECEIVE_ENABLE_BIT);
      wait_evt();
      `CHK("slave address", addr, saddr)
      rd_chk(`I2CRX_OFF_CTRL, ACKST | RECEIVE_ENABLE_BIT, 32'h0000_0000, "ack status");
      clr_evt();
      for (int i = 0; i < 6; i++) begin
         tx_byte <= 8'($random(seed));
         ack_data_bit = (i == 5);
         xfer(1'b1, `I2CRX_OFF_CTRL, RECEIVE_ENABLE_BIT);
         if (i == 1) begin
            xfer(1'b1, `I2CRX_OFF_BUF, 32'h0000_00a5);
            xfer(1'b1, `I2CRX_OFF_CTRL, RECEIVE_ENABLE_BIT);
         end
         wait_evt();
         `CHK("scl held", 1'b1, scl_oe)
         rd_chk(`I2CRX_OFF_CTRL, RECEIVE_ENABLE_BIT, 32'h0000_0000, "receive_enable_bit cleared");
         rd_chk(`I2CRX_OFF_STAT, 32'h0000_0037, exp_stat(i), "status");
         repeat (40) @(posedge clk);
         `CHK("scl still held", 1'b1, scl_oe)
         if (i != 2) begin
            rd_chk(`I2CRX_OFF_BUF, 32'hffff_ffff, {24'h00_0000, tx_byte}, "rx byte");
            rd_chk(`I2CRX_OFF_STAT, ONE << `I2CRX_STAT_BF, 32'h0000_0000, "bf cleared");
         end
         clr_evt();
         xfer(1'b1, `I2CRX_OFF_CTRL, ACK_SEQUENCE_ENABLE_BIT | (32'(ack_data_bit) << `I2CRX_CTRL_ACK_DATA_BIT));
         wait_evt();
         `CHK("master ack", ack_data_bit, mack)
         clr_evt();
      end
      xfer(1'b1, `I2CRX_OFF_CTRL, PEN);
      wait_evt();
      `CHK("stop seen", 1'b1, stop_seen)
      clr_evt();
      // second frame: slave stays silent on its address
      ack_en <= 1'b0;
      xfer(1'b1, `I2CRX_OFF_CTRL, START_ENABLE_BIT);
      wait_evt();
      clr_evt();
      xfer(1'b1, `I2CRX_OFF_BUF, {24'h00_0000, addr});
      wait_evt();
      rd_chk(`I2CRX_OFF_CTRL, ACKST, ACKST, "ack status nack");
      wrap_up();
   end
endmodule
